// >>> hw/pgt_cnt16.v
// One 16-bit count register with software load, increment and clear
`timescale 1ns/1ps
`default_nettype none
`include "pgt_regs.vh"
module pgt_cnt16
(
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        load,
	input  wire [15:0] load_data,
	input  wire        inc,
	input  wire        clr,
	output reg  [15:0] count
);
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			count <= `PGT_COUNT_RST;
		else if (load)
			count <= load_data;
		else if (clr)
			count <= `PGT_COUNT_RST;
		else if (inc)
			count <= count + `PGT_COUNT_ONE;
	end
endmodule
`default_nettype wire

// >>> hw/pgt_regs.vh
// Register offsets, control fields, reset values and prescale counts for the paired timers
`ifndef PGT_REGS_VH
`define PGT_REGS_VH

`define PGT_ADDR_W        8
`define PGT_DATA_W        16
`define PGT_NUM_TMR       4

`define PGT_OFS_CTRL0     8'h00
`define PGT_OFS_COUNT0    8'h04
`define PGT_OFS_PERIOD0   8'h08
`define PGT_OFS_STATUS    8'h0C
`define PGT_OFS_MASK      8'h0D

`define PGT_CTL_ON        15
`define PGT_CTL_SIDL      13
`define PGT_CTL_SLPRUN    12
`define PGT_CTL_GATE      6
`define PGT_CTL_PS_HI     5
`define PGT_CTL_PS_LO     4
`define PGT_CTL_T32       3
`define PGT_CTL_EXT       1

`define PGT_CTL_WMASK_EVEN 16'hB07A
`define PGT_CTL_WMASK_ODD  16'hB072

`define PGT_CTRL_RST      16'h0000
`define PGT_COUNT_RST     16'h0000
`define PGT_PERIOD_RST    16'hFFFF
`define PGT_COUNT_ONE     16'h0001
`define PGT_COUNT_ALL1    16'hFFFF
`define PGT_FLAGS_RST     4'h0

`define PGT_PS_W          8
`define PGT_PS_RST        8'h00
`define PGT_PS_ONE        8'h01
`define PGT_PS_DIV1       8'h00
`define PGT_PS_DIV8       8'h07
`define PGT_PS_DIV64      8'h3F
`define PGT_PS_DIV256     8'hFF
`define PGT_PS_SEL1       2'h0
`define PGT_PS_SEL8       2'h1
`define PGT_PS_SEL64      2'h2

`endif

// >>> hw/pgt_tick.v
// Count-event source of one timer: clock select, gating and input prescaler
`timescale 1ns/1ps
`default_nettype none
`include "pgt_regs.vh"
module pgt_tick
(
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire       run,
	input  wire       ext_sel,
	input  wire       gate_en,
	input  wire [1:0] ps_sel,
	input  wire       ext_in,
	input  wire       gate_in,
	output reg        tick
);
	reg  [`PGT_PS_W-1:0] ps_cnt;
	reg                  ext_prev;
	reg  [`PGT_PS_W-1:0] ps_last;
	wire                 raw_event;

	// Gate mode counts system clocks while the gate is high; else edge or clock
	assign raw_event = gate_en ? gate_in : (ext_sel ? (ext_in & ~ext_prev) : 1'b1);

	always @*
	begin
		case (ps_sel)
			`PGT_PS_SEL1:  ps_last = `PGT_PS_DIV1;
			`PGT_PS_SEL8:  ps_last = `PGT_PS_DIV8;
			`PGT_PS_SEL64: ps_last = `PGT_PS_DIV64;
			default:       ps_last = `PGT_PS_DIV256;
		endcase
	end

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			ps_cnt   <= `PGT_PS_RST;
			ext_prev <= 1'b0;
			tick     <= 1'b0;
		end
		else
		begin
			ext_prev <= ext_in;
			tick     <= 1'b0;
			if (!run)
				ps_cnt <= `PGT_PS_RST;
			else if (raw_event)
			begin
				if (ps_cnt >= ps_last)
				begin
					ps_cnt <= `PGT_PS_RST;
					tick   <= 1'b1;
				end
				else
					ps_cnt <= ps_cnt + `PGT_PS_ONE;
			end
		end
	end
endmodule
`default_nettype wire

// >>> hw/pgt_timers.v
// Two pairs of 16-bit timers, each pair usable as one 32-bit timer or counter
// How it works
// - Four 16-bit timers in two pairs; each pair may join into one 32-bit timer.
// - Pair modes: two 16-bit timers, one 32-bit timer, one 32-bit synchronous counter.
// - Separate 16-bit timers offer every 16-bit mode but asynchronous counting.
// - Gated operation, selectable prescaler, and running through idle and sleep.
// - Combined pair interrupts when 32-bit count equals 32-bit period.
// - Only the first pair's timers feed the capture and compare time base.
// - Each lone 16-bit timer runs as synchronous timer or synchronous counter.
// - Only the first pair produces the event trigger output.
// - In 32-bit use the even timer holds low half, odd timer high half.
// - In 32-bit use the odd control register is ignored; even one controls all.
// - 32-bit pair uses even clock and gate, flags match on odd timer flag.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pgt_regs.vh"
module pgt_timers
(
	input  wire                   clk_sys,
	input  wire                   rst_n,
	input  wire [`PGT_ADDR_W-1:0] reg_addr,
	input  wire [`PGT_DATA_W-1:0] reg_wdata,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	output reg  [`PGT_DATA_W-1:0] reg_rdata,
	input  wire [3:0]             ext_clk_in,
	input  wire [3:0]             gate_in,
	input  wire                   cpu_idle,
	input  wire                   cpu_sleep,
	output reg                    irq,
	output reg                    event_trig,
	output wire [15:0]            tb_a_low_count,
	output wire [15:0]            tb_a_high_count,
	output reg  [1:0]             tb_period_evt
);
	reg  [15:0] timer_ctrl [0:3];
	reg  [15:0] timer_period [0:3];
	reg  [3:0]  irq_status;
	reg  [3:0]  irq_mask;
	reg  [3:0]  next_status;
	reg  [3:0]  next_mask;
	reg  [15:0] next_rdata;
	wire [63:0] count_all;
	wire [3:0]  tick_all;
	wire [3:0]  evt_all;
	wire [1:0]  pair_t32;
	wire [1:0]  pair_match32;
	wire [1:0]  pair_lo_all1;
	integer     k;

	// Only the even timer of each pair carries the join bit
	assign pair_t32[0] = timer_ctrl[0][`PGT_CTL_T32];
	assign pair_t32[1] = timer_ctrl[2][`PGT_CTL_T32];

	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1)
		begin : g_pair
			// Low word from the even timer, high word from the odd one
			assign pair_match32[p] = tick_all[2*p] & pair_t32[p] &
				(count_all[32*p+31:32*p] == {timer_period[2*p+1], timer_period[2*p]});
			assign pair_lo_all1[p] = (count_all[32*p+15:32*p] == `PGT_COUNT_ALL1);
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < `PGT_NUM_TMR; i = i + 1)
		begin : g_tmr
			wire        run;
			wire        t32;
			wire        match16;
			wire        inc;
			wire        clr;
			wire        load;
			wire [15:0] cnt;
			wire [15:0] ctl;

			assign t32 = pair_t32[i/2];
			// Joined pair takes every setting from the even register
			assign ctl = t32 ? timer_ctrl[(i/2)*2] : timer_ctrl[i];
			// Stop in idle only when asked; run in sleep when enabled
			assign run = ctl[`PGT_CTL_ON] & ~(cpu_idle & ctl[`PGT_CTL_SIDL]) &
				~(cpu_sleep & ~ctl[`PGT_CTL_SLPRUN]);

			// Even clock and gate pins serve the joined pair
			pgt_tick u_tick
			(
				.clk_sys (clk_sys),
				.rst_n   (rst_n),
				.run     (run),
				.ext_sel (ctl[`PGT_CTL_EXT]),
				.gate_en (ctl[`PGT_CTL_GATE]),
				.ps_sel  (ctl[`PGT_CTL_PS_HI:`PGT_CTL_PS_LO]),
				.ext_in  (ext_clk_in[t32 ? (i/2)*2 : i]),
				.gate_in (gate_in[t32 ? (i/2)*2 : i]),
				.tick    (tick_all[i])
			);

			assign cnt     = count_all[16*i+15:16*i];
			assign match16 = tick_all[i] & ~t32 & (cnt == timer_period[i]);
			assign load    = reg_wr & (reg_addr == `PGT_OFS_COUNT0 + i);

			if (i % 2 == 0)
			begin : g_even
				assign inc = t32 ? (tick_all[i] & ~pair_match32[i/2])
					: (tick_all[i] & ~match16);
				assign clr = t32 ? pair_match32[i/2] : match16;
				assign evt_all[i] = match16;
			end
			else
			begin : g_odd
				// High half carries when the low half rolls over
				assign inc = t32 ? (tick_all[i-1] & pair_lo_all1[i/2] & ~pair_match32[i/2])
					: (tick_all[i] & ~match16);
				assign clr = t32 ? pair_match32[i/2] : match16;
				assign evt_all[i] = t32 ? pair_match32[i/2] : match16;
			end

			pgt_cnt16 u_cnt
			(
				.clk_sys   (clk_sys),
				.rst_n     (rst_n),
				.load      (load),
				.load_data (reg_wdata),
				.inc       (inc),
				.clr       (clr),
				.count     (count_all[16*i+15:16*i])
			);
		end
	endgenerate

	// Time base leaves only from the first pair
	assign tb_a_low_count  = count_all[15:0];
	assign tb_a_high_count = count_all[31:16];

	// Control and period registers
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			for (k = 0; k < `PGT_NUM_TMR; k = k + 1)
			begin
				timer_ctrl[k]   <= `PGT_CTRL_RST;
				timer_period[k] <= `PGT_PERIOD_RST;
			end
		end
		else if (reg_wr)
		begin
			for (k = 0; k < `PGT_NUM_TMR; k = k + 1)
			begin
				if (reg_addr == `PGT_OFS_CTRL0 + k)
					timer_ctrl[k] <= reg_wdata &
						((k % 2 == 0) ? `PGT_CTL_WMASK_EVEN : `PGT_CTL_WMASK_ODD);
				if (reg_addr == `PGT_OFS_PERIOD0 + k)
					timer_period[k] <= reg_wdata;
			end
		end
	end

	// Sticky flags: a match in the clearing cycle survives
	always @*
	begin
		next_status = irq_status;
		next_mask   = irq_mask;
		if (reg_wr && reg_addr == `PGT_OFS_STATUS)
			next_status = irq_status & ~reg_wdata[3:0];
		if (reg_wr && reg_addr == `PGT_OFS_MASK)
			next_mask = reg_wdata[3:0];
		next_status = next_status | evt_all;
	end

	always @*
	begin
		next_rdata = {`PGT_DATA_W{1'b0}};
		for (k = 0; k < `PGT_NUM_TMR; k = k + 1)
		begin
			if (reg_addr == `PGT_OFS_CTRL0 + k)
				next_rdata = timer_ctrl[k];
			if (reg_addr == `PGT_OFS_COUNT0 + k)
				next_rdata = count_all[16*k+:16];
			if (reg_addr == `PGT_OFS_PERIOD0 + k)
				next_rdata = timer_period[k];
		end
		if (reg_addr == `PGT_OFS_STATUS)
			next_rdata = {12'h000, irq_status};
		if (reg_addr == `PGT_OFS_MASK)
			next_rdata = {12'h000, irq_mask};
	end

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			irq_status    <= `PGT_FLAGS_RST;
			irq_mask      <= `PGT_FLAGS_RST;
			irq           <= 1'b0;
			event_trig    <= 1'b0;
			tb_period_evt <= 2'b00;
			reg_rdata     <= {`PGT_DATA_W{1'b0}};
		end
		else
		begin
			irq_status    <= next_status;
			irq_mask      <= next_mask;
			irq           <= |(next_status & next_mask);
			// Trigger from the first pair only; second pair has none
			event_trig    <= pair_t32[0] ? evt_all[1] : evt_all[0];
			tb_period_evt <= evt_all[1:0];
			reg_rdata     <= reg_rd ? next_rdata : {`PGT_DATA_W{1'b0}};
		end
	end
endmodule
`default_nettype wire

// >>> verification/pgt_chk.sv
// Port checker for the paired timers
`timescale 1ns/1ps
`default_nettype none
`include "pgt_regs.vh"
module pgt_chk
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        irq,
	input wire logic        event_trig,
	input wire logic [15:0] tb_a_low_count,
	input wire logic [15:0] tb_a_high_count,
	input wire logic [1:0]  tb_period_evt
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_rd; reg_rdata != 16'h0000 |-> $past(reg_rd); endproperty
	property p_trig; event_trig |-> tb_period_evt != 2'h0; endproperty
	property p_lo0; tb_period_evt[0] |-> tb_a_low_count == 16'h0000; endproperty
	property p_hi0; tb_period_evt[1] |-> tb_a_high_count == 16'h0000; endproperty
	property p_j32; tb_period_evt[1] && event_trig |-> tb_a_low_count == 16'h0000; endproperty
	property p_inc; $changed(tb_a_low_count) && !$past(reg_wr) |->
		tb_a_low_count == $past(tb_a_low_count) + 16'h0001 || tb_a_low_count == 16'h0000; endproperty
	property p_wr; reg_wr && reg_addr == `PGT_OFS_COUNT0 |=> tb_a_low_count == $past(reg_wdata); endproperty
	property p_irq; $fell(irq) |-> $past(reg_wr); endproperty
	a_rd: assert property (p_rd) else $error("read data outside slot");
	a_trig: assert property (p_trig) else $error("trigger without match");
	a_lo0: assert property (p_lo0) else $error("low count not cleared");
	a_hi0: assert property (p_hi0) else $error("high count not cleared");
	a_j32: assert property (p_j32) else $error("joined low half not zero");
	a_inc: assert property (p_inc) else $error("low count jump");
	a_wr: assert property (p_wr) else $error("count write lost");
	a_irq: assert property (p_irq) else $error("irq fell by itself");
	cover property (event_trig);
	cover property (tb_period_evt[1]);
	cover property ($fell(irq));
	cover property ($rose(irq));
endmodule
`default_nettype wire

// >>> verification/pgt_timers_tb_top.sv
// Self-checking bench for the paired timers
`timescale 1ns/1ps
`default_nettype none
`include "pgt_regs.vh"
module pgt_timers_tb_top;
	logic        clk_sys = 0;
	logic        rst_n = 0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 0;
	logic        reg_rd = 0;
	logic [3:0]  ext_clk_in = 4'h0;
	logic [3:0]  gate_in = 4'h0;
	logic        cpu_idle = 0;
	logic        cpu_sleep = 0;
	wire  [15:0] reg_rdata, tb_a_low_count, tb_a_high_count;
	wire  [1:0]  tb_period_evt;
	wire         irq, event_trig;
	int          mismatches = 0;
	int          n_compared = 0;
	int          p, n;
	logic [7:0]  i, k;
	logic [15:0] c;
	logic [18:0] tbl [4] = '{19'h50004, 19'h40005, 19'h40002, 19'h48003};
	pgt_timers u_pgt_timers (.*);
	always #12.5 clk_sys = ~clk_sys;
	task chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		mismatches += (s !== e);
		if (s !== e)
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk_sys);
		reg_wr <= 0;
		@(posedge clk_sys);
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 chk("rdata", reg_rdata, e);
		@(posedge clk_sys);
	endtask
	task wt(input logic s);
		k = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		while ((s ? tb_period_evt[1] : event_trig) !== 1'b1 && k < 90);
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		results();
	end
	initial
	begin
		p = $urandom(96323);
		repeat (12) @(posedge clk_sys);
		rst_n <= 1;
		for (k = 0; k < 15; k++)
			rd(k, (k > 7 && k < 12) ? `PGT_PERIOD_RST : `PGT_CTRL_RST);
		for (i = 0; i < 4; i++)
		begin
			wr(i, 16'hFFFF);
			rd(i, i[0] ? `PGT_CTL_WMASK_ODD : `PGT_CTL_WMASK_EVEN);
			wr(i, 16'h0000);
		end
		p = $urandom % 6 + 2;
		wr(8'h08, p[15:0]);
		wr(8'h0D, 16'h0005);
		wr(8'h00, 16'h8000);
		wt(0);
		wt(0);
		chk("gap", k, p + 1);
		chk("irq", irq, 1);
		wr(8'h00, 16'h0000);
		rd(8'h0C, 16'h0001);
		wr(8'h0C, 16'h000F);
		chk("irq", irq, 0);
		wr(8'h04, 16'hFFFD);
		wr(8'h08, 16'h0001);
		wr(8'h09, 16'h0001);
		wr(8'h00, 16'h8008);
		wr(8'h01, 16'h8000);
		wt(1);
		chk("lo", tb_a_low_count, 16'h0000);
		chk("hi", tb_a_high_count, 16'h0000);
		rd(8'h0C, 16'h0002);
		wr(8'h00, 16'h0000);
		wr(8'h01, 16'h0000);
		wr(8'h0C, 16'h000F);
		wr(8'h0A, 16'h0002);
		wr(8'h02, 16'h8000);
		n = 0;
		repeat (30)
		begin
			@(posedge clk_sys);
			n += event_trig;
		end
		chk("trig", n, 0);
		chk("irq", irq, 1);
		wr(8'h02, 16'h0000);
		rd(8'h0C, 16'h0004);
		wr(8'h0C, 16'h000F);
		wr(8'h08, 16'hFFFF);
		for (i = 0; i < 4; i++)
		begin
			cpu_idle <= tbl[i][2];
			cpu_sleep <= tbl[i][1];
			wr(8'h00, tbl[i][18:3]);
			@(posedge clk_sys);
			c = tb_a_low_count;
			repeat (5) @(posedge clk_sys);
			chk("run", tb_a_low_count != c, tbl[i][0]);
		end
		cpu_idle <= 0;
		cpu_sleep <= 0;
		n = $urandom % 20 + 1;
		for (i = 0; i < 3; i++)
		begin
			wr(8'h00, 16'h0000);
			wr(8'h04, 16'h0000);
			wr(8'h00, (i == 0) ? 16'h8002 : ((i == 1) ? 16'h8012 : 16'h8040));
			if (i == 2)
			begin
				gate_in <= 4'h1;
				repeat (n) @(posedge clk_sys);
				gate_in <= 4'h0;
			end
			else
			begin
				repeat ((i == 0) ? n : 16)
				begin
					ext_clk_in <= 4'h1;
					@(posedge clk_sys);
					ext_clk_in <= 4'h0;
					@(posedge clk_sys);
				end
			end
			repeat (3) @(posedge clk_sys);
			rd(8'h04, (i == 1) ? 16'h0002 : n[15:0]);
		end
		results();
	end
endmodule
bind pgt_timers pgt_chk u_pgt_chk (.*);
`default_nettype wire
